// File: verilog/mmg_guard.sv
/*
 management-mode memory guard: window registers, access decision, revision word.
 assumes the core presents one access request per cycle, synchronous to REF_CLK.
*/
// Contract
// - variable hit when address 51:17 masked equals base 51:17 masked
// - fixed low window is A_0000h to B_FFFFh, no register involved
// - mask bit 0 enables fixed window protection
// - mask bit 1 enables variable window protection
// - base register holds variable window base in bits 51:17
// - mask register holds variable window mask in bits 51:17
// - compare, base and mask bits above implemented width are dropped
// - revision word readable at offset FEFCh from handler memory base
// - revision bits 15:0 hold the version level
// - revision bit 16 always reads one; code reads zero in reset and until the first REF_CLK edge after it
// - revision bit 17 always reads one; code reads zero in reset and until the first REF_CLK edge after it
// - all other revision bits reserved, read zero
// - only the 64-bit save layout is used
// - registers outside the save layout are not saved automatically
`timescale 1ns/1ps
`include "mmg_defs.svh"
module mmg_guard #(
	parameter int PA_BITS = `MMG_PA_W,
	parameter logic [`MMG_REV_LVL_W-1:0] REV_LEVEL = `MMG_REV_LEVEL_DEF // arbitrary value
) (
	input wire logic REF_CLK,
	input wire logic RST_N,
	input wire logic CFG_WR,
	input wire logic CFG_SEL,
	input wire logic [63:0] CFG_WDATA,
	output logic [63:0] CFG_BASE_RDATA,
	output logic [63:0] CFG_MASK_RDATA,
	input wire logic ACC_VALID,
	input wire logic [63:0] ACC_ADDR,
	input wire logic IN_MGMT_MODE,
	input wire logic [63:0] HANDLER_MEMORY_BASE,
	output logic ACC_DONE,
	output logic ACC_IN_FIXED,
	output logic ACC_IN_VARIABLE,
	output logic ACC_BLOCKED,
	output logic ACC_REV_HIT,
	output logic [31:0] REV_WORD
);
	// ***************************************
	// window registers
	// ***************************************
	logic [PA_BITS-1:0] base_reg, base_next;
	logic [PA_BITS-1:0] mask_reg, mask_next;
	logic fix_en_reg, fix_en_next;
	logic var_en_reg, var_en_next;
	logic [PA_BITS-1:0] field_mask;

	always_comb begin
		field_mask = '0;
		for (int b = `MMG_WIN_LSB; b <= `MMG_WIN_MSB; b++) begin
			if (b < PA_BITS) begin
				field_mask[b] = 1'b1;
			end
		end
	end

	always_comb begin
		base_next = base_reg;
		mask_next = mask_reg;
		fix_en_next = fix_en_reg;
		var_en_next = var_en_reg;
		if (CFG_WR && CFG_SEL == `MMG_SEL_BASE) begin
			base_next = CFG_WDATA[PA_BITS-1:0] & field_mask;
		end
		if (CFG_WR && CFG_SEL == `MMG_SEL_MASK) begin
			mask_next = CFG_WDATA[PA_BITS-1:0] & field_mask;
			fix_en_next = CFG_WDATA[`MMG_FIX_EN_BIT];
			var_en_next = CFG_WDATA[`MMG_VAR_EN_BIT];
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			base_reg <= '0;
			mask_reg <= '0;
			fix_en_reg <= 1'b0;
			var_en_reg <= 1'b0;
		end else begin
			base_reg <= base_next;
			mask_reg <= mask_next;
			fix_en_reg <= fix_en_next;
			var_en_reg <= var_en_next;
		end
	end

	// ***************************************
	// register read-back
	// ***************************************
	logic [63:0] base_rd_next, mask_rd_next;
	always_comb begin
		base_rd_next = '0;
		mask_rd_next = '0;
		base_rd_next[PA_BITS-1:0] = base_reg;
		mask_rd_next[PA_BITS-1:0] = mask_reg;
		mask_rd_next[`MMG_FIX_EN_BIT] = fix_en_reg;
		mask_rd_next[`MMG_VAR_EN_BIT] = var_en_reg;
	end

	// ***************************************
	// window match
	// ***************************************
	mmg_match_if mif ();
	assign mif.addr = mmg_pkg::paddr_t'(ACC_ADDR[PA_BITS-1:0]);
	assign mif.base = mmg_pkg::paddr_t'(base_reg);
	assign mif.mask = mmg_pkg::paddr_t'(mask_reg);
	mmg_window_match #(.PA_BITS(PA_BITS)) u_match (.m(mif));

	// ***************************************
	// access decision, one cycle
	// ***************************************
	mmg_pkg::decide_e st_reg, st_next;
	logic fix_q_next, var_q_next, blk_next, rev_next;
	logic fix_q_reg, var_q_reg, blk_reg, rev_hit_reg;
	logic [63:0] rev_addr;
	// only the 64-bit layout: revision word at base plus FEFCh
	assign rev_addr = HANDLER_MEMORY_BASE + 64'(`MMG_REV_OFFSET);

	always_comb begin
		st_next = ACC_VALID ? mmg_pkg::DECIDE_VALID : mmg_pkg::DECIDE_IDLE;
		fix_q_next = ACC_VALID && mif.fix_hit;
		var_q_next = ACC_VALID && mif.var_hit;
		blk_next = ACC_VALID && !IN_MGMT_MODE &&
			((mif.fix_hit && fix_en_reg) || (mif.var_hit && var_en_reg));
		rev_next = ACC_VALID && (ACC_ADDR[PA_BITS-1:2] == rev_addr[PA_BITS-1:2]);
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			st_reg <= mmg_pkg::DECIDE_IDLE;
			fix_q_reg <= 1'b0;
			var_q_reg <= 1'b0;
			blk_reg <= 1'b0;
			rev_hit_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			fix_q_reg <= fix_q_next;
			var_q_reg <= var_q_next;
			blk_reg <= blk_next;
			rev_hit_reg <= rev_next;
		end
	end

	// ***************************************
	// revision word, read-only, zero in reset, constant after
	// ***************************************
	logic [31:0] rev_word_next, rev_word_reg;
	always_comb begin
		rev_word_next = '0;
		rev_word_next[`MMG_REV_LVL_W-1:0] = REV_LEVEL;
		rev_word_next[`MMG_REV_IO_BIT] = 1'b1;
		rev_word_next[`MMG_REV_RELOC_BIT] = 1'b1;
	end
	// no write path exists, so writes never alter it
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			rev_word_reg <= '0;
		end else begin
			// nothing else is saved or restored on mode change
			rev_word_reg <= rev_word_next;
		end
	end

	logic [63:0] base_rd_reg, mask_rd_reg;
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			base_rd_reg <= '0;
			mask_rd_reg <= '0;
		end else begin
			base_rd_reg <= base_rd_next;
			mask_rd_reg <= mask_rd_next;
		end
	end

	assign CFG_BASE_RDATA = base_rd_reg;
	assign CFG_MASK_RDATA = mask_rd_reg;
	assign ACC_DONE = (st_reg == mmg_pkg::DECIDE_VALID);
	assign ACC_IN_FIXED = fix_q_reg;
	assign ACC_IN_VARIABLE = var_q_reg;
	assign ACC_BLOCKED = blk_reg;
	assign ACC_REV_HIT = rev_hit_reg;
	assign REV_WORD = rev_word_reg;

	// ***************************************
	// assertions
	// ***************************************
	a_block_fixed: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		(ACC_VALID && !IN_MGMT_MODE && fix_en_reg && ACC_ADDR[PA_BITS-1:0] >= `MMG_FIX_LO
		&& ACC_ADDR[PA_BITS-1:0] <= `MMG_FIX_HI) |=> ACC_BLOCKED)
		else $error("fixed window hit not blocked");
	a_fixed_range: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		(ACC_VALID && ACC_ADDR[PA_BITS-1:0] == `MMG_FIX_HI + 52'h1) |=> !ACC_IN_FIXED)
		else $error("address past fixed window flagged");
	a_mgmt_pass: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		(ACC_VALID && IN_MGMT_MODE) |=> !ACC_BLOCKED)
		else $error("management mode access blocked");
	a_var_en_off: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		(ACC_VALID && !var_en_reg && !mif.fix_hit) |=> !ACC_BLOCKED)
		else $error("disabled variable window blocked");
	a_var_match: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		ACC_VALID |=> ACC_IN_VARIABLE == ((($past(ACC_ADDR[PA_BITS-1:0]) ^ $past(base_reg))
		& $past(mask_reg) & field_mask) == '0))
		else $error("variable window match wrong");
	a_rev_bits: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		$past(RST_N) |-> (REV_WORD[17:16] == 2'b11 && REV_WORD[31:18] == '0))
		else $error("revision flag bits wrong");
	a_rev_level: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		$past(RST_N) |-> REV_WORD[15:0] == REV_LEVEL)
		else $error("revision level wrong");
	a_mask_write: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		(CFG_WR && CFG_SEL == `MMG_SEL_MASK) |=> ##1 (CFG_MASK_RDATA[1:0] == $past(CFG_WDATA[1:0], 2)))
		else $error("mask write not visible");
	a_base_low: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		##1 CFG_BASE_RDATA[16:0] == '0)
		else $error("base low bits not zero");
	c_blocked: cover property (@(posedge REF_CLK) ACC_BLOCKED && ACC_IN_VARIABLE);
	c_fixed: cover property (@(posedge REF_CLK) ACC_BLOCKED && ACC_IN_FIXED);
	c_rev: cover property (@(posedge REF_CLK) ACC_REV_HIT);
endmodule : mmg_guard

// File: verilog/mmg_defs.svh
/*
 constants for the management-mode memory guard: field positions, fixed window,
 revision word layout and register access codes. assumes inclusion by bare name.
*/
`ifndef MMG_DEFS_SVH
`define MMG_DEFS_SVH

`define MMG_PA_W 52
`define MMG_WIN_LSB 17
`define MMG_WIN_MSB 51
`define MMG_FIX_EN_BIT 0
`define MMG_VAR_EN_BIT 1
`define MMG_FIX_LO 52'h0_0000_000A_0000
`define MMG_FIX_HI 52'h0_0000_000B_FFFF
`define MMG_REV_OFFSET 16'hFEFC
`define MMG_REV_LVL_W 16
`define MMG_REV_IO_BIT 16
`define MMG_REV_RELOC_BIT 17
`define MMG_REV_LEVEL_DEF 16'h0102 // arbitrary value
`define MMG_SEL_BASE 1'b0
`define MMG_SEL_MASK 1'b1

`endif

// File: verilog/mmg_pkg.sv
/*
 types for the management-mode memory guard.
 assumes mmg_defs.svh is on the include path.
*/
`include "mmg_defs.svh"
package mmg_pkg;
	typedef logic [`MMG_PA_W-1:0] paddr_t;
	typedef enum logic {DECIDE_IDLE, DECIDE_VALID} decide_e;
endpackage : mmg_pkg

// File: verilog/mmg_match_if.sv
/*
 carrier between the guard top and its window matcher.
 assumes one clock domain; purely combinational content.
*/
`timescale 1ns/1ps
`include "mmg_defs.svh"
interface mmg_match_if;
	mmg_pkg::paddr_t addr;
	mmg_pkg::paddr_t base;
	mmg_pkg::paddr_t mask;
	logic fix_hit;
	logic var_hit;
	modport top (output addr, output base, output mask, input fix_hit, input var_hit);
	modport matcher (input addr, input base, input mask, output fix_hit, output var_hit);
endinterface : mmg_match_if

// File: verilog/mmg_window_match.sv
/*
 window matcher: fixed low window range test and masked variable window test.
 assumes addresses wider than the implemented width are already dropped.
*/
`timescale 1ns/1ps
`include "mmg_defs.svh"
module mmg_window_match #(
	parameter int PA_BITS = `MMG_PA_W
) (
	mmg_match_if.matcher m
);
	logic [PA_BITS-1:0] cmp_bits;
	genvar i;
	// per-bit masked compare, bits above width omitted
	generate
		for (i = 0; i < PA_BITS; i = i + 1) begin : g_cmp
			if (i >= `MMG_WIN_LSB && i <= `MMG_WIN_MSB) begin : g_act
				assign cmp_bits[i] = ((m.addr[i] & m.mask[i]) == (m.base[i] & m.mask[i]));
			end else begin : g_off
				assign cmp_bits[i] = 1'b1;
			end
		end
	endgenerate
	assign m.var_hit = &cmp_bits;
	assign m.fix_hit = (m.addr >= `MMG_FIX_LO) && (m.addr <= `MMG_FIX_HI);
endmodule : mmg_window_match

// File: sim/mmg_core_model.sv
/*
 core access model: presents the bench's access requests at the guard's access port.
 assumes the bench raises go just after a rising edge and holds it for one cycle.
*/
`timescale 1ns/1ps
module mmg_core_model (
	input wire logic go,
	input wire logic [63:0] addr,
	input wire logic mm,
	output logic acc_valid,
	output logic [63:0] acc_addr,
	output logic in_mgmt_mode
);
	// ************************************
	// request lines
	// ************************************
	// no write path toward the revision word exists here
	// released address shows the inverse of the last value
	always_comb begin
		acc_valid = go;
		acc_addr = go ? addr : ~addr;
		in_mgmt_mode = mm;
	end
endmodule : mmg_core_model

// File: sim/mmg_guard_tb_top.sv
/*
 testbench for the memory guard: config writes, readback, access decisions, revision word.
 assumes the design files under verilog/ are compiled first.
*/
`timescale 1ns/1ps
`define CHK(act, exp) begin compares++; if ((act) !== (exp)) begin miscompares++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, act, exp); end end
module mmg_guard_tb_top;
	// ************************************
	// declarations
	// ************************************
	localparam logic [15:0] REV_LEVEL = 16'h1234; // arbitrary value
	localparam logic [63:0] HBASE = 64'h0000_0000_0003_0000;
	localparam logic [51:0] REV_ADDR = 52'h0_0000_0003_FEFC;
	logic ref_clk, rst_n, cfg_wr, cfg_sel, go, mm, acc_valid, in_mgmt_mode;
	logic acc_done, in_fix, in_var, blocked, rev_hit;
	logic [63:0] cfg_wdata, addr, acc_addr, base_rd, mask_rd, base_m, mask_m;
	logic [31:0] rev_word;
	int miscompares;
	int compares;
	logic [63:0] addrs [11] = '{64'h0000_0000_0009_FFFF, 64'h0000_0000_000A_0000, 64'h0000_0000_000B_FFFF,
		64'h0000_0000_000C_0000, 64'h0000_0000_0010_0000, 64'h0000_0000_0013_FFFF, 64'h0000_0000_0014_0000,
		64'h0000_0000_0003_FEFC, 64'h0000_0000_0003_FEF8, 64'h0010_0000_000A_0000, 64'h0010_0000_0003_FEFC};

	mmg_core_model core (.go(go), .addr(addr), .mm(mm), .acc_valid(acc_valid), .acc_addr(acc_addr),
		.in_mgmt_mode(in_mgmt_mode));
	mmg_guard #(.REV_LEVEL(REV_LEVEL)) dut (.REF_CLK(ref_clk), .RST_N(rst_n), .CFG_WR(cfg_wr),
		.CFG_SEL(cfg_sel), .CFG_WDATA(cfg_wdata), .CFG_BASE_RDATA(base_rd), .CFG_MASK_RDATA(mask_rd),
		.ACC_VALID(acc_valid), .ACC_ADDR(acc_addr), .IN_MGMT_MODE(in_mgmt_mode),
		.HANDLER_MEMORY_BASE(HBASE), .ACC_DONE(acc_done), .ACC_IN_FIXED(in_fix),
		.ACC_IN_VARIABLE(in_var), .ACC_BLOCKED(blocked), .ACC_REV_HIT(rev_hit), .REV_WORD(rev_word));

	// ************************************
	// expectations and tasks
	// ************************************
	function automatic logic [4:0] expect_flags(input logic [63:0] a, input logic m);
		logic fix;
		logic hit;
		logic blk;
		fix = (a[51:0] >= 52'h0_0000_000A_0000) && (a[51:0] <= 52'h0_0000_000B_FFFF);
		hit = ((a[51:17] ^ base_m[51:17]) & mask_m[51:17]) == '0;
		blk = !m && ((fix && mask_m[0]) || (hit && mask_m[1]));
		return {1'b1, fix, hit, blk, a[51:2] == REV_ADDR[51:2]};
	endfunction : expect_flags

	task automatic end_of_test();
		if (miscompares == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : end_of_test

	task automatic cfg_write(input logic sel, input logic [63:0] d);
		@(posedge ref_clk) #1;
		cfg_wr = 1'b1;
		cfg_sel = sel;
		cfg_wdata = d;
		@(posedge ref_clk) #1;
		cfg_wr = 1'b0;
		repeat (2) @(posedge ref_clk);
		#1;
		if (sel) begin
			mask_m = d & 64'h000F_FFFF_FFFE_0003;
		end else begin
			base_m = d & 64'h000F_FFFF_FFFE_0000;
		end
	endtask : cfg_write

	task automatic access(input logic [63:0] a, input logic m);
		logic [4:0] exp;
		exp = expect_flags(a, m);
		@(posedge ref_clk) #1;
		`CHK({acc_done, in_fix, in_var, blocked, rev_hit}, 5'h00)
		go = 1'b1;
		addr = a;
		mm = m;
		@(posedge ref_clk) #1;
		go = 1'b0;
		`CHK({acc_done, in_fix, in_var, blocked, rev_hit}, exp)
	endtask : access

	// ************************************
	// clock, watchdog, tests
	// ************************************
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	initial begin
		#100000;
		miscompares++;
		end_of_test();
	end

	initial begin
		miscompares = 0;
		compares = 0;
		rst_n = 1'b0;
		cfg_wr = 1'b0;
		cfg_sel = 1'b0;
		cfg_wdata = 64'h0000_0000_0000_0000;
		go = 1'b0;
		addr = 64'h0000_0000_0000_0000;
		mm = 1'b0;
		repeat (16) @(posedge ref_clk);
		#1;
		`CHK(rev_word, 32'h0000_0000)
		`CHK(base_rd, 64'h0000_0000_0000_0000)
		`CHK(mask_rd, 64'h0000_0000_0000_0000)
		rst_n = 1'b1;
		repeat (2) @(posedge ref_clk);
		#1;
		`CHK(rev_word, {14'h0000, 1'b1, 1'b1, REV_LEVEL})
		// base 10_0000h, mask 256 Kbytes: windows kept apart
		cfg_write(1'b0, 64'hFFF0_0000_0011_FFFF);
		`CHK(base_rd, base_m)
		for (int e = 0; e < 4; e++) begin
			cfg_write(1'b1, 64'hFFF0_0000_FFFC_0000 | 64'(e));
			`CHK(mask_rd, mask_m)
			for (int i = 0; i < 11; i++) begin
				access(addrs[i], 1'b0);
				access(addrs[i], 1'b1);
			end
		end
		end_of_test();
	end
endmodule : mmg_guard_tb_top
